//--- logic/i2c_clock_stretch_control.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module i2c_clock_stretch_control (
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    input  wire logic                                 awvalid,
    output logic                                      awready,
    input  wire logic [i2c_stretch_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                                 wvalid,
    output logic                                      wready,
    input  wire logic [31:0]                          wdata,
    input  wire logic [3:0]                           wstrb,
    output logic                                      bvalid,
    input  wire logic                                 bready,
    output logic [1:0]                                bresp,
    input  wire logic                                 arvalid,
    output logic                                      arready,
    input  wire logic [i2c_stretch_pkg::ADDR_W-1:0]   araddr,
    output logic                                      rvalid,
    input  wire logic                                 rready,
    output logic [31:0]                               rdata,
    output logic [1:0]                                rresp,
    input  wire logic [i2c_stretch_pkg::NUM_CHAN-1:0] serialClockIo,
    input  wire logic [i2c_stretch_pkg::NUM_CHAN-1:0] sclIn,
    output logic      [i2c_stretch_pkg::NUM_CHAN-1:0] sclOut,
    output logic      [i2c_stretch_pkg::NUM_CHAN-1:0] sclOe,
    output logic      [i2c_stretch_pkg::NUM_CHAN-1:0] sdaOut,
    output logic      [i2c_stretch_pkg::NUM_CHAN-1:0] sdaOe
);
    import i2c_stretch_pkg::*;

    logic              awHeld, next_awHeld, wHeld, next_wHeld;
    logic [ADDR_W-1:0] awAddr, next_awAddr;
    logic [7:0]        wByte, next_wByte;
    logic              wLane, next_wLane;
    logic              next_awready, next_wready, next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready, next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              doWrite;
    logic [7:0]        ctrl      [NUM_CHAN];
    logic [7:0]        next_ctrl [NUM_CHAN];
    logic [7:0]        status    [NUM_CHAN];
    logic [2:0]        done      [NUM_CHAN];

    // A register is hit only on an aligned word inside the channel range.
    function automatic logic reg_hit(logic [ADDR_W-1:0] a);
        reg_hit = (a[1:0] == 2'h0) && (a - CTRL0_OFFSET < CTRL_STRIDE * 12'(NUM_CHAN));
    endfunction : reg_hit

    function automatic logic [1:0] reg_index(logic [ADDR_W-1:0] a);
        reg_index = 2'((a - CTRL0_OFFSET) >> 2);
    endfunction : reg_index

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        chan_if ch ();
        assign ch.ctrl   = ctrl[i];
        assign done[i]   = ch.reqDone;
        assign status[i] = ch.status;
        i2c_chan_engine u_engine (
            .clk     (clk),
            .nrst    (nrst),
            .ch      (ch.engine),
            .linkClk (serialClockIo[i]),
            .sclIn   (sclIn[i]),
            .sclOut  (sclOut[i]),
            .sclOe   (sclOe[i]),
            .sdaOut  (sdaOut[i]),
            .sdaOe   (sdaOe[i])
        );
        // A finished request must be gone one cycle later unless software rewrote it.
        req_clear_a: assert property (@(posedge clk) disable iff (!nrst)
            |done[i] && !doWrite |=> (ctrl[i][STOP_REQ_POS:START_REQ_POS] & $past(done[i])) == 3'h0)
            else $error("finished request not cleared");
    end

    // ----------------------------------------------------------------
    // Write channel and control registers
    // ----------------------------------------------------------------
    // Address and data are parked independently so either may come first;
    // the response goes out only when both are in.
    assign doWrite = awHeld & wHeld & ~bvalid;

    always_comb begin
        next_awHeld = awHeld;
        next_awAddr = awAddr;
        next_wHeld  = wHeld;
        next_wByte  = wByte;
        next_wLane  = wLane;
        next_bvalid = bvalid;
        next_bresp  = bresp;
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_awAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_wHeld = 1'b1;
            next_wByte = wdata[7:0];
            next_wLane = wstrb[0];
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = reg_hit(awAddr) ? RESP_OKAY : RESP_DECERR;
        end
        next_awready = ~next_awHeld & ~next_bvalid;
        next_wready  = ~next_wHeld & ~next_bvalid;
        for (int i = 0; i < NUM_CHAN; i++) begin
            // Finished requests drop, but a software write in the same
            // cycle lands on top so a fresh request is never lost.
            next_ctrl[i] = ctrl[i];
            next_ctrl[i][STOP_REQ_POS:START_REQ_POS] =
                ctrl[i][STOP_REQ_POS:START_REQ_POS] & ~done[i];
            if (doWrite && wLane && reg_hit(awAddr) && reg_index(awAddr) == 2'(i)) begin
                next_ctrl[i] = wByte;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld  <= 1'b0;
            awAddr  <= '0;
            wHeld   <= 1'b0;
            wByte   <= 8'h00;
            wLane   <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            for (int i = 0; i < NUM_CHAN; i++) begin
                ctrl[i] <= CTRL_RESET;
            end
        end else begin
            awHeld  <= next_awHeld;
            awAddr  <= next_awAddr;
            wHeld   <= next_wHeld;
            wByte   <= next_wByte;
            wLane   <= next_wLane;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            for (int i = 0; i < NUM_CHAN; i++) begin
                ctrl[i] <= next_ctrl[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0000_0000;
            next_rresp  = RESP_DECERR;
            if (reg_hit(araddr)) begin
                next_rresp = RESP_OKAY;
                next_rdata[7:0] = ctrl[reg_index(araddr)];
                next_rdata[STATUS_POS +: 8] = status[reg_index(araddr)];
            end
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Only one write and one read are under way, so readies stay low while an answer waits.
    write_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while a response waits");
    read_busy_a: assert property (rvalid |-> !arready)
        else $error("read taken while data waits");
    bad_write_a: assert property (doWrite && !reg_hit(awAddr) |=> bresp == RESP_DECERR)
        else $error("unmapped write not refused");
    bad_read_a: assert property (arvalid && arready && !reg_hit(araddr)
        |=> rresp == RESP_DECERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule : i2c_clock_stretch_control

//--- logic/i2c_stretch_pkg.sv
package i2c_stretch_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 5;
    localparam int         COND_PHASE_NS   = 2500;
    localparam int         COND_PHASE_CYC  = (COND_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] COND_PHASE_LAST = 10'(COND_PHASE_CYC - 1);
    localparam logic [9:0] TIMER_RESET     = 10'h000;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          NUM_CHAN       = 3;
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] CTRL0_OFFSET   = 12'h000;
    localparam logic [11:0] CTRL_STRIDE    = 12'h004;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int          ACK_WAIT_POS   = 0;
    localparam int          FORCE_LOW_POS  = 1;
    localparam int          NINTH_WAIT_POS = 2;
    localparam int          DELAY_PH_POS   = 3;
    localparam int          START_REQ_POS  = 4;
    localparam int          STOP_REQ_POS   = 6;
    localparam int          COND_SEL_POS   = 7;
    localparam int          STATUS_POS     = 8;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;
    // ----------------------------------------------------------------
    // Serial bit positions
    // ----------------------------------------------------------------
    localparam logic [3:0] BIT_CNT_RESET   = 4'h0;
    localparam logic [3:0] ACK_BIT_INDEX   = 4'h7;
    localparam logic [3:0] NINTH_BIT_INDEX = 4'h8;
    localparam logic [1:0] LAST_STEP       = 2'h2;

    typedef enum logic [1:0] {COND_START, COND_RESTART, COND_STOP} cond_kind_t;
    typedef enum logic {C_IDLE, C_RUN} cond_state_t;
endpackage : i2c_stretch_pkg

//--- logic/chan_if.sv
`timescale 1ns/10ps
interface chan_if;
    logic [7:0] ctrl;
    logic [2:0] reqDone;
    logic [7:0] status;
    modport regs   (output ctrl, input reqDone, input status);
    modport engine (input ctrl, output reqDone, output status);
endinterface : chan_if

//--- logic/i2c_chan_engine.sv
`timescale 1ns/10ps
module i2c_chan_engine (
    input  wire logic clk,
    input  wire logic nrst,
    chan_if.engine    ch,
    input  wire logic linkClk,
    input  wire logic sclIn,
    output logic      sclOut,
    output logic      sclOe,
    output logic      sdaOut,
    output logic      sdaOe
);
    import i2c_stretch_pkg::*;

    logic        lk1, lk2, lkPrev, sc1, sc2;
    logic [3:0]  bitCnt, next_bitCnt;
    logic        hold8, next_hold8, hold9, next_hold9;
    logic        sdaHeld, next_sdaHeld, next_sclOe, next_sdaOe;
    logic [1:0]  step, next_step, drv;
    logic [9:0]  timer, next_timer;
    logic [2:0]  reqDone, next_reqDone;
    cond_state_t state, next_state;
    cond_kind_t  kind, next_kind;
    logic        fall, stretched, advance, trigger;
    logic [1:0]  oeDly;

    // Returns {clock low, data low} for each step of a bus condition.
    function automatic logic [1:0] cond_drive(cond_kind_t k, logic [1:0] s);
        case (k)
            COND_START:   cond_drive = (s == 2'h0) ? 2'h0 : (s == 2'h1) ? 2'h1 : 2'h3;
            COND_RESTART: cond_drive = (s == 2'h0) ? 2'h2 : (s == 2'h1) ? 2'h0 : 2'h1;
            COND_STOP:    cond_drive = (s == 2'h0) ? 2'h3 : (s == 2'h1) ? 2'h1 : 2'h0;
            default:      cond_drive = 2'h0;
        endcase
    endfunction : cond_drive

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // The link clock idles high, so its stages start high too; starting
            // low would pull the clock line down for two cycles after a reset.
            lk1    <= 1'b1;
            lk2    <= 1'b1;
            lkPrev <= 1'b1;
            sc1    <= 1'b1;
            sc2    <= 1'b1;
            oeDly  <= 2'h0;
        end else begin
            lk1    <= linkClk;
            lk2    <= lk1;
            lkPrev <= lk2;
            sc1    <= sclIn;
            sc2    <= sc1;
            oeDly  <= {oeDly[0], sclOe};
        end
    end

    // While we release the line but someone else keeps it low, the bit
    // position must freeze, otherwise the eighth and ninth holds slip.
    assign fall      = lkPrev & ~lk2;
    // Our own release needs two cycles to reach sc2, so only a release that
    // has been out that long can reveal another device holding the line.
    assign stretched = lkPrev & ~sc2 & ~sclOe & ~oeDly[1];
    assign advance   = fall & ~stretched;
    // A finished request still reads set for one cycle; masking it with the
    // done pulse keeps the same condition from starting twice.
    assign trigger   = ch.ctrl[COND_SEL_POS]
                     & (|(ch.ctrl[STOP_REQ_POS:START_REQ_POS] & ~reqDone));
    assign ch.reqDone = reqDone;
    assign ch.status  = {state == C_RUN, stretched, hold9, hold8, bitCnt};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_kind    = kind;
        next_step    = step;
        next_timer   = timer;
        next_sdaHeld = sdaHeld;
        next_bitCnt  = bitCnt;
        next_reqDone = 3'h0;
        drv          = cond_drive(kind, step);
        next_hold8 = ch.ctrl[ACK_WAIT_POS]
                   & (hold8 | (advance & (bitCnt == ACK_BIT_INDEX)));
        next_hold9 = ch.ctrl[NINTH_WAIT_POS] & ch.ctrl[DELAY_PH_POS]
                   & (hold9 | (advance & (bitCnt == NINTH_BIT_INDEX)));
        if (advance && !hold8 && !hold9) begin
            next_bitCnt = (bitCnt == NINTH_BIT_INDEX) ? BIT_CNT_RESET : bitCnt + 4'h1;
        end
        case (state)
            C_IDLE: begin
                if (trigger) begin
                    next_state = C_RUN;
                    next_step  = 2'h0;
                    next_timer = TIMER_RESET;
                    next_kind  = ch.ctrl[START_REQ_POS] ? COND_START :
                                 ch.ctrl[START_REQ_POS + 1] ? COND_RESTART : COND_STOP;
                end
            end
            C_RUN: begin
                if (timer == COND_PHASE_LAST) begin
                    next_timer = TIMER_RESET;
                    if (step == LAST_STEP) begin
                        next_state   = C_IDLE;
                        next_bitCnt  = BIT_CNT_RESET;
                        next_sdaHeld = kind != COND_STOP;
                        next_reqDone = {kind == COND_STOP, kind == COND_RESTART,
                                        kind == COND_START};
                    end else begin
                        next_step = step + 2'h1;
                    end
                end else begin
                    next_timer = timer + 10'h001;
                end
            end
            default: next_state = C_IDLE;
        endcase
        // Force-low wins over everything, a condition in flight included.
        next_sclOe = ch.ctrl[FORCE_LOW_POS]
                   | ((state == C_RUN) ? drv[1] : (hold8 | hold9 | ~lk2));
        next_sdaOe = (state == C_RUN) ? drv[0] : sdaHeld;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state   <= C_IDLE;
            kind    <= COND_START;
            step    <= 2'h0;
            timer   <= TIMER_RESET;
            sdaHeld <= 1'b0;
            bitCnt  <= BIT_CNT_RESET;
            hold8   <= 1'b0;
            hold9   <= 1'b0;
            reqDone <= 3'h0;
            sclOe   <= 1'b0;
            sdaOe   <= 1'b0;
            sclOut  <= 1'b0;
            sdaOut  <= 1'b0;
        end else begin
            state   <= next_state;
            kind    <= next_kind;
            step    <= next_step;
            timer   <= next_timer;
            sdaHeld <= next_sdaHeld;
            bitCnt  <= next_bitCnt;
            hold8   <= next_hold8;
            hold9   <= next_hold9;
            reqDone <= next_reqDone;
            sclOe   <= next_sclOe;
            sdaOe   <= next_sdaOe;
            sclOut  <= 1'b0;
            sdaOut  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ack_hold_set_a: assert property (ch.ctrl[ACK_WAIT_POS] && advance && !hold9
        && bitCnt == 4'h7 |=> hold8 ##1 sclOe) else $error("no hold after bit 8");
    ack_release_a: assert property (!ch.ctrl[ACK_WAIT_POS] |=> !hold8)
        else $error("bit 8 hold not cleared");
    force_low_a: assert property (ch.ctrl[FORCE_LOW_POS] |=> sclOe)
        else $error("force low ignored");
    clock_follow_a: assert property (!ch.ctrl[FORCE_LOW_POS] && state == C_IDLE
        && !hold8 && !hold9 |=> sclOe == !$past(lk2)) else $error("clock not passed out");
    ninth_hold_set_a: assert property (ch.ctrl[NINTH_WAIT_POS] && ch.ctrl[DELAY_PH_POS]
        && advance && bitCnt == 4'h8 |=> hold9) else $error("no hold after bit 9");
    ninth_release_a: assert property (!ch.ctrl[NINTH_WAIT_POS] |=> !hold9)
        else $error("bit 9 hold not cleared");
    start_cond_a: assert property (state == C_IDLE && trigger && ch.ctrl[START_REQ_POS]
        |=> state == C_RUN ##1 !sdaOe) else $error("start sequence wrong");
    select_gate_a: assert property (state == C_IDLE && !ch.ctrl[COND_SEL_POS]
        |=> state == C_IDLE) else $error("condition without select");
    stretch_freeze_a: assert property (stretched && state == C_IDLE
        |=> bitCnt == $past(bitCnt)) else $error("advanced while stretched");

    ack_hold_c:   cover property ($rose(hold8));
    ninth_hold_c: cover property ($rose(hold9));
    stop_done_c:  cover property (reqDone[2]);
    stretch_c:    cover property (stretched ##1 !stretched);
endmodule : i2c_chan_engine

//--- verif/i2c_bus_peer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Other devices on the shared clock line
// ----------------------------------------------------------------
module i2c_bus_peer (
    input  wire logic       clk,
    input  wire logic [2:0] sclOe,
    input  wire logic [2:0] stretch,
    output logic      [2:0] linkClk,
    output logic      [2:0] sclLine
);
    // The line has a pull-up, so it is low while any party pulls it down.
    assign sclLine = ~sclOe & ~stretch;

    initial linkClk = 3'h7;

    // The link clock stands high between frames; each half period is 16 cycles.
    task automatic clock_bits(input int ch, input int falls);
        int n;
        repeat (falls) begin
            n = 0;
            // A new bit waits up to 5000 cycles while someone still holds the line low.
            while (sclLine[ch] !== 1'b1 && n < 5000) begin
                @(posedge clk);
                n++;
            end
            repeat (16) @(posedge clk);
            linkClk[ch] <= 1'b0;
            repeat (16) @(posedge clk);
            linkClk[ch] <= 1'b1;
        end
    endtask : clock_bits

    // A misbehaving peer that clocks straight through a stretch; the block
    // must not count this fall.
    task automatic rogue_fall(input int ch);
        linkClk[ch] <= 1'b0;
        repeat (16) @(posedge clk);
        linkClk[ch] <= 1'b1;
        repeat (16) @(posedge clk);
    endtask : rogue_fall
endmodule : i2c_bus_peer

//--- verif/tb.sv
`timescale 1ns/10ps
module tb;
    import i2c_stretch_pkg::*;
    typedef struct {
        logic [11:0] addr;
        logic [7:0]  wd;
        logic [1:0]  resp;
        logic [31:0] rd;
    } row_t;
    logic        clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [2:0]  linkClk, sclLine, sclOut, sclOe, sdaOut, sdaOe, stretch;
    int          errors, samplesChecked;
    row_t        rows[6] = '{
        '{12'h000, 8'h09, RESP_OKAY, 32'h9}, '{12'h004, 8'h05, RESP_OKAY, 32'h5},
        '{12'h008, 8'h0d, RESP_OKAY, 32'hd}, '{12'h00c, 8'h55, RESP_DECERR, 32'h0},
        '{12'h002, 8'h01, RESP_DECERR, 32'h0}, '{12'h000, 8'h00, RESP_OKAY, 32'h0}};

    i2c_clock_stretch_control u_dut (.clk(clk), .nrst(nrst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .serialClockIo(linkClk),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
    i2c_bus_peer u_peer (.clk(clk), .sclOe(sclOe), .stretch(stretch), .linkClk(linkClk),
        .sclLine(sclLine));

    always #2.5 clk = ~clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wready === 1'b1) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask : rd

    task automatic expect_reg(input logic [11:0] a, input logic [31:0] exp,
                              input logic [31:0] mask, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check(d & mask, exp, what);
    endtask : expect_reg

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic [11:0] a;
        logic [7:0]  b;
        int          n;
        clk = 1'b0;
        nrst = 1'b0;
        {awvalid, wvalid, arvalid} = 3'h0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'h1;
        stretch = 3'h0;
        errors = 0;
        samplesChecked = 0;
        cyc(2);
        nrst <= 1'b1;
        cyc(3);
        check(32'({bvalid, rvalid, sclOe, sdaOe, sclOut, sdaOut}), 32'h0, "idle after reset");
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wd, r);
            check(r, rows[i].resp, "write response");
            rd(rows[i].addr, d, r);
            check(r, rows[i].resp, "read response");
            check(d, rows[i].rd, "read data");
        end
        $display("register rows done");
        wr(12'h004, 8'h02, r);
        cyc(4);
        check(sclOe[1], 1'b1, "forced low");
        wr(12'h004, 8'h00, r);
        cyc(4);
        check(sclOe[1], 1'b0, "force released");
        $display("force low done");
        wr(12'h000, 8'h01, r);
        u_peer.clock_bits(0, 7);
        cyc(8);
        check(sclOe[0], 1'b0, "held too early");
        u_peer.clock_bits(0, 1);
        cyc(8);
        check(sclOe[0], 1'b1, "hold after eighth");
        check(sclLine[0], 1'b0, "line held low");
        expect_reg(12'h000, 32'h1000, 32'h1000, "eighth hold flag");
        wr(12'h000, 8'h00, r);
        cyc(4);
        check(sclOe[0], 1'b0, "eighth hold cleared");
        u_peer.clock_bits(0, 1);
        $display("eighth bit wait done");
        wr(12'h000, 8'h04, r);
        u_peer.clock_bits(0, 9);
        cyc(8);
        check(sclOe[0], 1'b0, "ninth hold without delay");
        wr(12'h000, 8'h0c, r);
        u_peer.clock_bits(0, 9);
        cyc(8);
        check(sclOe[0], 1'b1, "hold after ninth");
        expect_reg(12'h000, 32'h2000, 32'h2000, "ninth hold flag");
        wr(12'h000, 8'h08, r);
        cyc(4);
        check(sclOe[0], 1'b0, "ninth hold cleared");
        wr(12'h000, 8'h00, r);
        $display("ninth bit wait done");
        stretch[2] <= 1'b1;
        cyc(10);
        expect_reg(12'h008, 32'h4000, 32'h4000, "stretch seen");
        u_peer.rogue_fall(2);
        expect_reg(12'h008, 32'h0, 32'h0f00, "no count while stretched");
        stretch[2] <= 1'b0;
        cyc(10);
        expect_reg(12'h008, 32'h0, 32'h4000, "stretch gone");
        $display("peer stretch done");
        wr(12'h004, 8'h0d, r);
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(3);
        check(32'({bvalid, rvalid, sclOe, sdaOe, sclOut, sdaOut}), 32'h0, "idle after second reset");
        expect_reg(12'h004, 32'h0, 32'hff, "control after reset");
        $display("second reset done");
        // Every channel runs start, repeated start and stop in turn.
        for (int ch = 0; ch < 3; ch++) begin
            for (int k = 0; k < 3; k++) begin
                a = 12'(ch * 4);
                b = 8'h10 << k;
                wr(a, b, r);
                wr(a, b | 8'h80, r);
                expect_reg(a, 32'h8000, 32'h8000, "condition busy");
                n = 0;
                d = 32'hff;
                while (d[4 + k] !== 1'b0 && n < 1000) begin
                    rd(a, d, r);
                    n++;
                end
                expect_reg(a, 32'h0, 32'h8000 | 32'(b), "condition finished");
                check(sdaOe[ch], k < 2, "data line after condition");
                wr(a, 8'h00, r);
            end
        end
        $display("conditions done");
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule : tb
